// file: hw/timer_params.svh
// Constants of the dual timer control and status block
//
// Notes on behaviour
// - Flag sets on an enabled capture, or on rollover in generate mode.
// - Flag clears only when software writes one; writing zero keeps it.
// - Run enable lets the counter count; clearing it halts the counter.
// - Interrupt enable gates whether this timer drives the interrupt output.
// - Interrupt enable never touches the flag; the flag records every event.
// - While the load bit is one, the load register is copied into the counter.
// - Generate mode: one reloads and keeps running, zero holds at termination.
// - Capture mode: one lets captures overwrite, zero keeps capture until read.
// - Capture enable accepts the external trigger; zero ignores it.
// - Generate enable lets pulses reach the generate output; zero suppresses.
// - Direction bit zero counts up, one counts down.
// - Mode bit zero selects generate mode, one selects capture mode.
// - Counter width is a build parameter from 8 through 32 bits.
// - Build option gives two timers (0) or one timer (1) without PWM.
// - Trigger polarity parameter: 0 active low, 1 active high.
// - Generate polarity parameter: 0 drives active low, 1 active high.
// - PWM: timer 0 load sets period (count+2), timer 1 load sets high time (count+1).
// - One interrupt output, OR of both timers' enabled interrupts.
// - Writing one to enable-all sets it and both run enables; zero clears it only.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Control/status bit positions, bit 0 most significant
`define BIT_ENABLE_ALL_TIMERS    21
`define BIT_PWM      22
`define BIT_TINT     23
`define BIT_ENT      24
`define BIT_ENIT     25
`define BIT_LOAD     26
`define BIT_ARHT     27
`define BIT_CAPT     28
`define BIT_GENT     29
`define BIT_UDT      30
`define BIT_MDT      31

// Address fields, bit 0 most significant
`define ADDR_DEC_LSB 26
`define ADDR_IDX_BIT 27
`define ADDR_SEL_HI  28
`define ADDR_SEL_LO  29

// Limits and reset values
`define WIDTH_MIN    8
`define WIDTH_MAX    32
`define CTRL_RESET   1'b0
`define WORD_RESET   32'h0000_0000

`endif

// file: hw/timer_pkg.sv
// Types and helpers shared by the dual timer block
package timer_pkg;

    typedef logic [0:31] word_t;
    typedef logic [0:3]  lane_t;

    typedef enum logic [1:0] {
        SEL_CSR  = 2'h0,
        SEL_TLR  = 2'h1,
        SEL_TCR  = 2'h2,
        SEL_NONE = 2'h3
    } reg_sel_t;

    // Byte lane merge of a write into an old word
    function automatic word_t lane_merge(input word_t old, input word_t wr, input lane_t be);
        word_t m;
        m = {{8{be[0]}}, {8{be[1]}}, {8{be[2]}}, {8{be[3]}}};
        return (old & ~m) | (wr & m);
    endfunction : lane_merge

endpackage : timer_pkg

// file: hw/timer_ctrl_if.sv
// Control and status signals between register file and one timer
`timescale 1ns/1ps
interface timer_ctrl_if #(parameter int WIDTH = 32);

    logic             run;
    logic             freeze;
    logic             count_down;
    logic             capture_mode;
    logic             reload_hold;
    logic             load_strobe;
    logic             capture_enable;
    logic             trig;
    logic             force_reload;
    logic             tlr_wr;
    logic             tlr_rd;
    logic [WIDTH-1:0] tlr_wdata;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] load_value;
    logic             event_pulse;

    modport ctrl (
        output run, freeze, count_down, capture_mode, reload_hold, load_strobe,
        output capture_enable, trig, force_reload, tlr_wr, tlr_rd, tlr_wdata,
        input  count, load_value, event_pulse
    );

    modport unit (
        input  run, freeze, count_down, capture_mode, reload_hold, load_strobe,
        input  capture_enable, trig, force_reload, tlr_wr, tlr_rd, tlr_wdata,
        output count, load_value, event_pulse
    );

endinterface : timer_ctrl_if

// file: hw/sync2.sv
// Two flip-flop synchroniser for outside levels
`timescale 1ns/1ps
module sync2 #(
    parameter int N = 1
)(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // Levels
    input  wire logic [N-1:0] d,
    output logic      [N-1:0] q
);

    logic [N-1:0] meta;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : sync2

// file: hw/timer_unit.sv
// One counter with load, capture and generate logic
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_unit #(
    parameter int WIDTH = 32
)(
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    // Control and status
    timer_ctrl_if.unit  tc
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] load_value;
    logic             carry_q;
    logic             expired;
    logic             locked;
    logic             trig_d;

    wire logic             run_ok     = tc.run & ~tc.freeze;
    wire logic             trig_rise  = tc.trig & ~trig_d;
    wire logic             at_end     = tc.count_down ? (count == {WIDTH{1'b0}})
                                                      : (count == {WIDTH{1'b1}});
    wire logic [WIDTH-1:0] next_count = tc.count_down ? count - 1'b1 : count + 1'b1;
    wire logic             reload_now = ~tc.capture_mode & (tc.force_reload | (carry_q & tc.reload_hold));
    wire logic             gen_step   = ~tc.capture_mode & ~tc.load_strobe & ~reload_now
                                        & run_ok & ~expired;
    wire logic             gen_event  = gen_step & at_end;
    wire logic             do_capture = tc.capture_mode & run_ok & tc.capture_enable & trig_rise
                                        & (tc.reload_hold | ~locked);

    assign tc.event_pulse = gen_event | do_capture;
    assign tc.count       = count;
    assign tc.load_value  = load_value;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
        end else if (tc.load_strobe | reload_now) begin
            count <= load_value;
        end else if (tc.capture_mode ? run_ok : gen_step) begin
            count <= next_count;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            carry_q <= `CTRL_RESET;
            expired <= `CTRL_RESET;
            trig_d  <= `CTRL_RESET;
        end else begin
            carry_q <= gen_event & tc.reload_hold;
            expired <= ~(tc.load_strobe | tc.capture_mode) & (expired | (gen_event & ~tc.reload_hold));
            trig_d  <= tc.trig;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            load_value <= '0;
            locked     <= `CTRL_RESET;
        end else begin
            if (tc.tlr_wr) begin
                load_value <= tc.tlr_wdata;
            end else if (do_capture) begin
                load_value <= count;
            end
            locked <= tc.capture_mode & (do_capture | (locked & ~tc.tlr_rd));
        end
    end

endmodule : timer_unit

// file: hw/dual_timer_ctrl_status.sv
// Dual timer register file, bus slave, pins and PWM
`timescale 1ns/1ps
`include "timer_params.svh"
module dual_timer_ctrl_status
    import timer_pkg::*;
#(
    parameter int    COUNT_WIDTH             = 32,
    parameter int    ONE_TIMER_ONLY          = 0,
    parameter logic  trigger0_polarity_param = 1'b1,
    parameter logic  trigger1_polarity_param = 1'b1,
    parameter logic  gen0_polarity_param     = 1'b1,
    parameter logic  gen1_polarity_param     = 1'b1,
    parameter word_t BASE_ADDR               = 32'h0000_0000
)(
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    // Peripheral bus, master side
    input  wire word_t OPB_ABus,
    input  wire lane_t OPB_BE,
    input  wire word_t OPB_DBus,
    input  wire logic  OPB_RNW,
    input  wire logic  OPB_select,
    input  wire logic  OPB_seqAddr,
    // Peripheral bus, slave side
    output word_t      TC_DBus,
    output logic       TC_errAck,
    output logic       TC_retry,
    output logic       TC_toutSup,
    output logic       TC_xferAck,
    // Capture triggers
    input  wire logic  capture_trigger_in0,
    input  wire logic  capture_trigger_in1,
    // Freeze
    input  wire logic  freeze_in,
    // Generate, PWM and interrupt outputs
    output logic       generate_pulse_out0,
    output logic       generate_pulse_out1,
    output logic       pulse_width_out,
    output logic       interrupt_out
);

    // ************************************************************
    // Build checks
    // ************************************************************

    localparam int NT = 2;

    if (COUNT_WIDTH < `WIDTH_MIN || COUNT_WIDTH > `WIDTH_MAX) begin : g_bad_width
        $error("counter width out of range");
    end
    if (ONE_TIMER_ONLY != 0 && ONE_TIMER_ONLY != 1) begin : g_bad_count
        $error("timer count option must be 0 or 1");
    end

    localparam logic [0:NT-1] TRIG_POL = {trigger0_polarity_param, trigger1_polarity_param};
    localparam logic [0:NT-1] GEN_POL  = {gen0_polarity_param, gen1_polarity_param};
    localparam logic [0:NT-1] PRESENT  = {1'b1, (ONE_TIMER_ONLY == 0)};
    localparam int            PAD      = 32 - COUNT_WIDTH;

    // ************************************************************
    // Control and status state
    // ************************************************************

    logic          enable_all_timers;
    logic [0:NT-1] pwm_en;
    logic [0:NT-1] irq_flag;
    logic [0:NT-1] run_enable;
    logic [0:NT-1] irq_enable;
    logic [0:NT-1] load_strobe;
    logic [0:NT-1] reload_hold;
    logic [0:NT-1] capture_enable;
    logic [0:NT-1] generate_enable;
    logic [0:NT-1] count_down;
    logic [0:NT-1] mode_select;
    logic          pwm_q;
    logic          xfer_ack_q;
    logic          err_ack_q;
    word_t         rd_q;

    wire logic [0:NT-1] next_irq_flag;
    wire logic [0:NT-1] next_run_enable;
    wire logic [0:NT-1] csr_wr;
    wire logic [0:NT-1] gen_active;
    wire logic [0:NT-1] unit_event;
    wire word_t         csr_rd  [0:NT-1];
    wire word_t         csr_new [0:NT-1];
    wire word_t         tlr_rd  [0:NT-1];
    wire word_t         tcr_rd  [0:NT-1];

    wire logic pwm_active = (ONE_TIMER_ONLY == 0) & (&pwm_en) & ~(|mode_select);

    // ************************************************************
    // Outside inputs
    // ************************************************************

    logic [2:0] sync_q;

    sync2 #(.N(3)) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .d       ({freeze_in,
                   capture_trigger_in0 ^ ~TRIG_POL[0],
                   capture_trigger_in1 ^ ~TRIG_POL[1]}),
        .q       (sync_q)
    );

    wire logic          freeze_s = sync_q[2];
    wire logic [0:NT-1] trig_s   = sync_q[1:0];

    // ************************************************************
    // Bus decode
    // ************************************************************

    wire logic     addr_hit  = OPB_select
                               & (OPB_ABus[0:`ADDR_DEC_LSB] == BASE_ADDR[0:`ADDR_DEC_LSB]);
    wire logic     acc_idx   = OPB_ABus[`ADDR_IDX_BIT];
    wire reg_sel_t acc_sel   = reg_sel_t'(OPB_ABus[`ADDR_SEL_HI:`ADDR_SEL_LO]);
    wire logic     mapped    = (acc_sel != SEL_NONE) & PRESENT[acc_idx];
    wire logic     accept    = addr_hit & ~xfer_ack_q & ~err_ack_q;
    wire logic     wr_ok     = accept & mapped & ~OPB_RNW;
    wire logic     rd_ok     = accept & mapped & OPB_RNW;
    wire word_t    lane_mask = lane_merge(`WORD_RESET, ~`WORD_RESET, OPB_BE);
    wire logic     enable_all_timers_wr  = (|csr_wr) & lane_mask[`BIT_ENABLE_ALL_TIMERS];
    wire logic     enable_all_timers_set = enable_all_timers_wr & OPB_DBus[`BIT_ENABLE_ALL_TIMERS];
    wire logic     enable_all_timers_clr = enable_all_timers_wr & ~OPB_DBus[`BIT_ENABLE_ALL_TIMERS];

    wire word_t    rd_mux    = (acc_sel == SEL_CSR) ? csr_rd[acc_idx] :
                               (acc_sel == SEL_TLR) ? tlr_rd[acc_idx] :
                               (acc_sel == SEL_TCR) ? tcr_rd[acc_idx] : `WORD_RESET;

    // ************************************************************
    // Per timer
    // ************************************************************

    timer_ctrl_if #(.WIDTH(COUNT_WIDTH)) tif [0:NT-1] ();

    for (genvar i = 0; i < NT; i++) begin : g_timer
        wire logic  sel_me  = (acc_idx == 1'(i));
        wire logic  tlr_sel = sel_me & (acc_sel == SEL_TLR);
        wire word_t tlr_new = lane_merge(tlr_rd[i], OPB_DBus, OPB_BE);
        wire logic  flag_clr = csr_wr[i] & lane_mask[`BIT_TINT] & OPB_DBus[`BIT_TINT];

        assign csr_rd[i]  = PRESENT[i] ? {{`BIT_ENABLE_ALL_TIMERS{1'b0}}, enable_all_timers, pwm_en[i],
                                          irq_flag[i], run_enable[i], irq_enable[i],
                                          load_strobe[i], reload_hold[i], capture_enable[i],
                                          generate_enable[i], count_down[i], mode_select[i]}
                                       : `WORD_RESET;
        assign tlr_rd[i]  = word_t'(tif[i].load_value);
        assign tcr_rd[i]  = word_t'(tif[i].count);
        assign csr_wr[i]  = wr_ok & sel_me & (acc_sel == SEL_CSR);
        assign csr_new[i] = lane_merge(csr_rd[i], OPB_DBus, OPB_BE);

        assign next_irq_flag[i]   = unit_event[i] | (irq_flag[i] & ~flag_clr);
        assign next_run_enable[i] = PRESENT[i] & (enable_all_timers_set
                                    | (csr_wr[i] ? csr_new[i][`BIT_ENT] : run_enable[i]));
        assign gen_active[i]      = unit_event[i] & ~mode_select[i] & generate_enable[i];
        assign unit_event[i]      = PRESENT[i] & tif[i].event_pulse;

        assign tif[i].run            = run_enable[i];
        assign tif[i].freeze         = freeze_s;
        assign tif[i].count_down     = count_down[i];
        assign tif[i].capture_mode   = mode_select[i];
        assign tif[i].reload_hold    = reload_hold[i];
        assign tif[i].load_strobe    = load_strobe[i];
        assign tif[i].capture_enable = capture_enable[i];
        assign tif[i].trig           = trig_s[i];
        assign tif[i].force_reload   = (i == 1) & pwm_active & gen_active[0];
        assign tif[i].tlr_wr         = wr_ok & tlr_sel;
        assign tif[i].tlr_rd         = rd_ok & tlr_sel;
        assign tif[i].tlr_wdata      = tlr_new[PAD:31];

        if (PRESENT[i]) begin : g_unit
            timer_unit #(.WIDTH(COUNT_WIDTH)) u_unit (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .tc      (tif[i])
            );
        end else begin : g_absent
            assign tif[i].count       = '0;
            assign tif[i].load_value  = '0;
            assign tif[i].event_pulse = 1'b0;
        end
    end

    // ************************************************************
    // Control register update
    // ************************************************************

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_flag   <= '0;
            run_enable <= '0;
        end else begin
            irq_flag   <= next_irq_flag;
            run_enable <= next_run_enable;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_all_timers <= `CTRL_RESET;
        end else if (enable_all_timers_set | enable_all_timers_clr) begin
            enable_all_timers <= enable_all_timers_set;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_en          <= '0;
            irq_enable      <= '0;
            load_strobe     <= '0;
            reload_hold     <= '0;
            capture_enable  <= '0;
            generate_enable <= '0;
            count_down      <= '0;
            mode_select     <= '0;
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (csr_wr[i]) begin
                    pwm_en[i]          <= csr_new[i][`BIT_PWM];
                    irq_enable[i]      <= csr_new[i][`BIT_ENIT];
                    load_strobe[i]     <= csr_new[i][`BIT_LOAD];
                    reload_hold[i]     <= csr_new[i][`BIT_ARHT];
                    capture_enable[i]  <= csr_new[i][`BIT_CAPT];
                    generate_enable[i] <= csr_new[i][`BIT_GENT];
                    count_down[i]      <= csr_new[i][`BIT_UDT];
                    mode_select[i]     <= csr_new[i][`BIT_MDT];
                end
            end
        end
    end

    // ************************************************************
    // PWM, generate and interrupt outputs
    // ************************************************************

    wire logic next_pwm   = pwm_active & (gen_active[0] | (pwm_q & ~gen_active[1]));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_q               <= `CTRL_RESET;
            generate_pulse_out0 <= ~GEN_POL[0];
            generate_pulse_out1 <= ~GEN_POL[1];
            interrupt_out       <= `CTRL_RESET;
        end else begin
            pwm_q               <= next_pwm;
            generate_pulse_out0 <= gen_active[0] ~^ GEN_POL[0];
            generate_pulse_out1 <= gen_active[1] ~^ GEN_POL[1];
            interrupt_out       <= |(irq_flag & irq_enable);
        end
    end

    assign pulse_width_out = pwm_q;

    // ************************************************************
    // Bus answer
    // ************************************************************

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            xfer_ack_q <= `CTRL_RESET;
            err_ack_q  <= `CTRL_RESET;
            rd_q       <= `WORD_RESET;
        end else begin
            xfer_ack_q <= accept & mapped;
            err_ack_q  <= accept & ~mapped;
            rd_q       <= rd_ok ? rd_mux : `WORD_RESET;
        end
    end

    assign TC_DBus    = rd_q;
    assign TC_xferAck = xfer_ack_q;
    assign TC_errAck  = err_ack_q;
    assign TC_retry   = 1'b0;
    assign TC_toutSup = 1'b0;

endmodule : dual_timer_ctrl_status

// file: test/timer_ctrl_properties.sv
// Port checks of the dual timer block
`timescale 1ns/1ps
module timer_ctrl_checker
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic  mclk,
    input wire logic  sys_rst,
    // Bus
    input wire logic  OPB_RNW,
    input wire logic  OPB_select,
    input wire word_t TC_DBus,
    input wire logic  TC_errAck,
    input wire logic  TC_retry,
    input wire logic  TC_toutSup,
    input wire logic  TC_xferAck,
    // Pins
    input wire logic  generate_pulse_out1,
    input wire logic  interrupt_out
);
    // ****************
    // Assertions
    // ****************
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic ack_any = TC_xferAck | TC_errAck;
    ack_single_a: assert property (ack_any |=> !ack_any) else $error("ack too long");
    ack_cause_a: assert property (ack_any |-> $past(OPB_select)) else $error("stray ack");
    ack_latency_a: assert property ($rose(OPB_select) |-> ##1 ack_any) else $error("late ack");
    ack_exclusive_a: assert property (!(TC_xferAck && TC_errAck)) else $error("two acks");
    idle_data_a: assert property (!TC_xferAck |-> TC_DBus == '0) else $error("data leak");
    fixed_zero_a: assert property (!TC_retry && !TC_toutSup) else $error("retry set");
    gen_pulse_a: assert property (generate_pulse_out1 |=> !generate_pulse_out1)
        else $error("generate pulse too long");
    irq_fall_a: assert property ($fell(interrupt_out) |-> $past(TC_xferAck && !OPB_RNW))
        else $error("interrupt fell without write");
    cover property ($rose(interrupt_out));
    cover property (generate_pulse_out1);
    cover property (TC_errAck);
endmodule : timer_ctrl_checker

bind dual_timer_ctrl_status timer_ctrl_checker u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .OPB_RNW(OPB_RNW), .OPB_select(OPB_select),
    .TC_DBus(TC_DBus), .TC_errAck(TC_errAck), .TC_retry(TC_retry), .TC_toutSup(TC_toutSup),
    .TC_xferAck(TC_xferAck), .generate_pulse_out1(generate_pulse_out1),
    .interrupt_out(interrupt_out)
);

// file: test/bus_master.sv
// Bus master model issuing single register transfers
`timescale 1ns/1ps
module bus_master
    import timer_pkg::*;
(
    // Clock
    input  wire logic  mclk,
    // Request
    output word_t      OPB_ABus,
    output lane_t      OPB_BE,
    output word_t      OPB_DBus,
    output logic       OPB_RNW,
    output logic       OPB_select,
    // Answer
    input  wire word_t TC_DBus,
    input  wire logic  TC_xferAck,
    input  wire logic  TC_errAck
);
    initial begin
        OPB_ABus = 32'hffff_ffff;
        OPB_BE = 4'hf;
        OPB_DBus = 32'h0;
        OPB_RNW = 1'b1;
        OPB_select = 1'b0;
    end
    // Request held until an ack is sampled or 16 cycles pass, then released
    task automatic xfer(input word_t a, input logic rnw, input word_t d,
                        output word_t q, output logic err);
        int n;
        @(posedge mclk);
        OPB_ABus <= a;
        OPB_RNW <= rnw;
        OPB_DBus <= d;
        OPB_select <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (TC_xferAck !== 1'b1 && TC_errAck !== 1'b1 && n < 16);
        q = TC_DBus;
        err = TC_errAck;
        OPB_select <= 1'b0;
        OPB_DBus <= ~d;
        OPB_ABus <= ~a;
    endtask : xfer
endmodule : bus_master

// file: test/tb.sv
// Self-checking bench of the dual timer block
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    logic        mclk, sys_rst, trig1, frz, rnw, sel, err, xack, eack;
    logic        gen0, gen1, pwm, irq;
    word_t       abus, dbus, rdata, tc_d, t;
    lane_t       be;
    int          num_errors, num_checks, cycles, n, m;
    int unsigned seed, v;
    dual_timer_ctrl_status #(.COUNT_WIDTH(8)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .OPB_ABus(abus), .OPB_BE(be), .OPB_DBus(dbus), .OPB_RNW(rnw), .OPB_select(sel),
        .OPB_seqAddr(1'b0), .TC_DBus(tc_d), .TC_errAck(eack), .TC_retry(), .TC_toutSup(),
        .TC_xferAck(xack), .capture_trigger_in0(1'b0), .capture_trigger_in1(trig1),
        .freeze_in(frz), .generate_pulse_out0(gen0), .generate_pulse_out1(gen1),
        .pulse_width_out(pwm), .interrupt_out(irq));
    bus_master u_bm (.mclk(mclk), .OPB_ABus(abus), .OPB_BE(be), .OPB_DBus(dbus),
        .OPB_RNW(rnw), .OPB_select(sel), .TC_DBus(tc_d), .TC_xferAck(xack), .TC_errAck(eack));
    // ****************
    // Tasks
    // ****************
    task automatic check(input word_t got, input word_t exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input word_t a, input word_t d);
        u_bm.xfer(a, 1'b0, d, rdata, err);
    endtask : wr
    task automatic rd(input word_t a, input word_t exp);
        u_bm.xfer(a, 1'b1, 32'h0, rdata, err);
        check(rdata, exp);
    endtask : rd
    task automatic pulse_trig();
        trig1 <= 1'b1;
        repeat (3) @(posedge mclk);
        trig1 <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : pulse_trig
    function automatic int unsigned xs(input int unsigned s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        sys_rst = 1'b1;
        trig1 = 1'b0;
        frz = 1'b0;
        seed = xs(32'd19);
        v = 8 + (seed & 32'h3f);
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(32'h10, 32'h0);
        rd(32'h14, 32'h0);
        u_bm.xfer(32'h1c, 1'b1, 32'h0, rdata, err);
        check({31'h0, err}, 32'h1);
        wr(32'h14, v);
        wr(32'h10, 32'h20);
        rd(32'h18, v);
        wr(32'h10, 32'hd6);
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check({31'h0, (n + 2 > v) && (n < v + 8)}, 32'h1);
        rd(32'h10, 32'h1d6);
        wr(32'h10, 32'h44);
        rd(32'h10, 32'h144);
        wr(32'h10, 32'h144);
        rd(32'h10, 32'h44);
        check({31'h0, irq}, 32'h0);
        wr(32'h10, 32'h20);
        wr(32'h10, 32'h96);
        n = 0;
        m = 0;
        repeat (v + 10) begin
            @(posedge mclk);
            n += (irq !== 1'b0);
            m += (gen1 === 1'b1);
        end
        check(n, 0);
        check(m, 1);
        rd(32'h10, 32'h196);
        frz <= 1'b1;
        repeat (4) @(posedge mclk);
        u_bm.xfer(32'h18, 1'b1, 32'h0, t, err);
        rd(32'h18, t);
        frz <= 1'b0;
        wr(32'h10, 32'h0);
        wr(32'h10, 32'h100);
        u_bm.xfer(32'h18, 1'b1, 32'h0, t, err);
        rd(32'h18, t);
        rd(32'h10, 32'h0);
        wr(32'h10, 32'h99);
        pulse_trig();
        rd(32'h10, 32'h199);
        wr(32'h10, 32'h191);
        pulse_trig();
        rd(32'h10, 32'h91);
        wr(32'h10, 32'h01);
        wr(32'h00, 32'h400);
        rd(32'h10, 32'h481);
        wr(32'h00, 32'h0);
        rd(32'h10, 32'h81);
        close_out();
    end
endmodule : tb
